// File: exc_seq_pkg.sv
// Constants and types shared by the exception vector sequencer
package exc_seq_pkg;
  // Vector table geometry
  localparam int unsigned VEC_BITS = 8;
  localparam int unsigned TABLE_ENTRIES = 256;
  localparam int unsigned TABLE_BYTES = 1024;
  localparam int unsigned CPU_DEFINED_VECS = 64;
  // Fixed vector numbers
  localparam logic [7:0] VEC_RESET_SP = 8'h00;
  localparam logic [7:0] VEC_RESET_PC = 8'h01;
  localparam logic [7:0] VEC_BUS_ERR = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV = 8'h05;
  localparam logic [7:0] VEC_BOUND = 8'h06;
  localparam logic [7:0] VEC_COND_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_LINE_A = 8'h0a;
  localparam logic [7:0] VEC_LINE_F = 8'h0b;
  localparam logic [7:0] VEC_HW_BREAKPOINT_INSTR = 8'h0c;
  localparam logic [7:0] VEC_FORMAT_ERR = 8'h0e;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTOVEC_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [7:0] VEC_USER_FIRST = 8'h40;
  // Function codes on function_code_lines, then acknowledge cycle type, frame format and last frame word index
  localparam logic [2:0] FC_SUPER_DATA = 3'h5;
  localparam logic [2:0] FC_SUPER_PROG = 3'h6;
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam logic [3:0] CPU_TYPE_IACK = 4'hf;
  localparam logic [3:0] FRAME_FMT_SHORT = 4'h0;
  localparam logic [2:0] FRAME_WORDS_LAST = 3'h3;
  // Status word field positions
  localparam int unsigned PSW_T1 = 15;
  localparam int unsigned PSW_T0 = 14;
  localparam int unsigned PSW_S = 13;
  localparam int unsigned PSW_MASK_LO = 8;
  // Register offsets
  localparam logic [7:0] OFS_VBR = 8'h00;
  localparam logic [7:0] OFS_PSW = 8'h04;
  localparam logic [7:0] OFS_SSP = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Reset values
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [15:0] PSW_RESET = 16'h2700;
  localparam logic [31:0] RESET_VEC_ADDR = 32'h0000_0000;
  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
  // Exception causes reported by the core
  typedef enum logic [3:0] {
    CAUSE_ILLEGAL = 4'h0, CAUSE_ZERO_DIV = 4'h1, CAUSE_BOUND = 4'h2, CAUSE_COND_TRAP = 4'h3,
    CAUSE_PRIV = 4'h4, CAUSE_TRACE = 4'h5, CAUSE_LINE_A = 4'h6, CAUSE_LINE_F = 4'h7,
    CAUSE_HW_BREAKPOINT_INSTR = 4'h8, CAUSE_FORMAT = 4'h9, CAUSE_TRAP = 4'ha, CAUSE_BUS_ERR = 4'hb,
    CAUSE_ADDR_ERR = 4'hc
  } exc_cause_t;
  // Sequencer states, one bit per step from ST_IDLE via ST_IACK to ST_DONE and from ST_RST_SP to ST_RST_PC
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_IACK = 3'b001, ST_PUSH = 3'b011, ST_VFETCH = 3'b010,
    ST_DONE = 3'b110, ST_RST_SP = 3'b111, ST_RST_PC = 3'b101
  } seq_state_t;
endpackage

// File: exception_vector_sequencer.sv
// Exception entry sequencer: vector lookup, status switch, frame push and handler load
// Functional notes
// (RL1) Table at base: 1024 bytes, 256 vectors
// (RL2) Vectors 0-63 processor, 192 user
// (RL3) Long-word entries; reset uses vectors 0,1
// (RL4) Vector fetch data space; reset program space
// (RL5) Only reset vector fixed; base relocatable
// (RL6) Address equals base plus vector times four
// (RL7) Interrupt vector comes from acknowledge cycle
// (RL8) Autovectors levels 1-7 use 25-31
// (RL9) Trap variants 0-15 map 32-47
// (RL10) Format error 14, spurious 24, reserved gaps
// (RL11) Fixed vectors 2 through 12
// (RL12) Vectors 64-255 user, external sources
// (RL13) Raise illegal, privilege, odd address exceptions
// (RL14) Copy status, set supervisor, clear trace
// (RL15) Frame holds status word and PC
// (RL16) Frame holds vector offset, format code
// (RL17) Format zero means four-word frame
// (RL18) Load PC, resume unless more pending
// (RL19) Others should not touch processor vectors
// (RL20) Reset reads two longs at zero
// (RL21) Acknowledge: type 1111, level on A4-1
// (RL22) CPU space type on A19-16
// (RL23) One long read before PC update
// (RL24) Frame pushed downward, stack pointer updated
module exception_vector_sequencer
  import exc_seq_pkg::*;
#(
  parameter int unsigned ADDR_W = 32 // System bus address width
) (
  input wire logic mclk_in, // Core clock
  input wire logic rstn_in, // Synchronous reset, low
  input wire logic [7:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic exc_req_in, // Core exception request pulse
  input wire exc_cause_t exc_cause_in, // Cause of that request
  input wire logic [3:0] trap_num_in, // Trap instruction variant
  input wire logic fetch_valid_in, // Instruction fetch address valid
  input wire logic [31:0] fetch_addr_in, // Instruction fetch address
  input wire logic oper_valid_in, // Operand access valid
  input wire logic oper_wide_in, // Operand is word or long
  input wire logic [31:0] oper_addr_in, // Operand address
  input wire logic priv_instr_in, // Decoded instruction is privileged
  input wire logic [31:0] fault_pc_in, // PC to save in the frame
  input wire logic [2:0] irq_level_in, // Interrupt level pins
  input wire logic bus_ack_in, // Bus cycle acknowledge pin
  input wire logic bus_autovec_in, // Source asks for autovector
  input wire logic [31:0] bus_rdata_in, // Bus read data pins
  output logic bus_req_out, // Bus cycle request
  output logic bus_write_out, // Bus cycle is a write
  output logic bus_long_out, // Long word cycle, else word
  output logic [2:0] bus_fc_out, // Function code lines
  output logic [ADDR_W-1:0] bus_addr_out, // Bus address
  output logic [31:0] bus_wdata_out, // Write data, words in low half
  output logic [31:0] pc_out, // Program counter
  output logic [15:0] psw_out, // Status word
  output logic busy_out, // Exception processing active
  output logic resume_out // Pulse: resume at new PC
);

  // Synchronised pin inputs: {irq, autovec, ack, rdata}
  logic [36:0] sync1_q, sync2_q;
  logic ack_s, autovec_s;
  logic [2:0] irq_s;
  logic [31:0] rdata_s;
  // Sequencer state and working registers
  seq_state_t state_q;
  logic release_q; // Waiting for acknowledge to drop
  logic [31:0] vbr_q, ssp_q, pc_q, saved_pc_q;
  logic [15:0] psw_q, saved_psw_q;
  logic [7:0] vec_q; // Vector being processed
  logic [2:0] ack_level_q; // Level under acknowledge
  logic [1:0] word_cnt_q; // Frame word index
  logic pend_q; // Exception waiting to run
  logic [7:0] pend_vec_q;
  logic [31:0] pend_pc_q;
  // Decoded events
  logic odd_event, core_event, new_event, irq_take, xfer_done, step;
  logic [7:0] new_vec;
  logic [31:0] push_addr;

  // Two-flop synchroniser for every pin input
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {irq_level_in, bus_autovec_in, bus_ack_in, bus_rdata_in};
      sync2_q <= sync1_q;
    end
  end
  assign {irq_s, autovec_s, ack_s, rdata_s} = sync2_q;

  // Map a core cause to its fixed vector number
  function automatic logic [7:0] cause_vec(input exc_cause_t c, input logic [3:0] tn);
    logic [7:0] v;
    v = VEC_ILLEGAL;
    unique case (c)
      CAUSE_ILLEGAL: v = VEC_ILLEGAL; // RL11
      CAUSE_ZERO_DIV: v = VEC_ZERO_DIV; // RL11
      CAUSE_BOUND: v = VEC_BOUND; // RL11
      CAUSE_COND_TRAP: v = VEC_COND_TRAP; // RL11
      CAUSE_PRIV: v = VEC_PRIV; // RL11
      CAUSE_TRACE: v = VEC_TRACE; // RL11
      CAUSE_LINE_A: v = VEC_LINE_A; // RL11
      CAUSE_LINE_F: v = VEC_LINE_F; // RL11
      CAUSE_HW_BREAKPOINT_INSTR: v = VEC_HW_BREAKPOINT_INSTR; // RL11
      CAUSE_FORMAT: v = VEC_FORMAT_ERR; // RL10
      CAUSE_TRAP: v = VEC_TRAP_BASE + {4'h0, tn}; // RL9
      CAUSE_BUS_ERR: v = VEC_BUS_ERR; // RL11
      CAUSE_ADDR_ERR: v = VEC_ADDR_ERR; // RL11
      default: v = VEC_ILLEGAL; // Unknown cause treated as illegal
    endcase
    return v;
  endfunction

  // Odd-address and privilege detection inside the block
  assign odd_event = (fetch_valid_in && fetch_addr_in[0]) ||
                     (oper_valid_in && oper_wide_in && oper_addr_in[0]); // RL13
  assign core_event = exc_req_in || (priv_instr_in && !psw_q[PSW_S]); // RL13
  assign new_event = odd_event || core_event;
  // Address error first, then privilege, then the reported cause
  always_comb begin
    if (odd_event) begin
      new_vec = VEC_ADDR_ERR; // RL13
    end else if (priv_instr_in && !psw_q[PSW_S]) begin
      new_vec = VEC_PRIV; // RL13
    end else begin
      new_vec = cause_vec(exc_cause_in, trap_num_in);
    end
  end
  // Interrupt accepted above the mask, level 7 always
  assign irq_take = (irq_s != 3'h0) && ((irq_s > psw_q[PSW_MASK_LO +: 3]) || (irq_s == 3'h7));
  // Bus handshake: request held until ack, then wait for ack to drop
  assign xfer_done = bus_req_out && ack_s;
  assign step = !bus_req_out && !release_q;
  assign push_addr = ssp_q - {29'h0, word_cnt_q, 1'b0} - 32'h2; // RL24

  // Pending exception latch; a new event wins over the clear
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pend_q <= 1'b0;
      pend_vec_q <= '0;
      pend_pc_q <= '0;
    end else if (new_event && (!pend_q || state_q == ST_IDLE)) begin
      pend_q <= 1'b1;
      pend_vec_q <= new_vec;
      pend_pc_q <= fault_pc_in;
    end else if (state_q == ST_IDLE && pend_q) begin
      pend_q <= 1'b0;
    end
  end

  // Sequencer state machine
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      state_q <= ST_RST_SP; // RL20
      word_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (pend_q) begin
            state_q <= ST_PUSH;
            word_cnt_q <= '0;
          end else if (irq_take) begin
            state_q <= ST_IACK; // RL7
          end
        end
        ST_IACK: if (xfer_done) begin
          state_q <= ST_PUSH;
          word_cnt_q <= '0;
        end
        ST_PUSH: if (xfer_done) begin
          if (word_cnt_q == FRAME_WORDS_LAST[1:0]) begin
            state_q <= ST_VFETCH; // RL15
          end else begin
            word_cnt_q <= word_cnt_q + 2'h1;
          end
        end
        ST_VFETCH: if (xfer_done) state_q <= ST_DONE; // RL23
        ST_RST_SP: if (xfer_done) state_q <= ST_RST_PC; // RL3
        ST_RST_PC: if (xfer_done) state_q <= ST_DONE; // RL3
        ST_DONE: if (step) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Vector number and acknowledged level
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      vec_q <= VEC_RESET_SP;
      ack_level_q <= '0;
    end else if (state_q == ST_IDLE && pend_q) begin
      vec_q <= pend_vec_q;
    end else if (state_q == ST_IDLE && irq_take) begin
      ack_level_q <= irq_s;
    end else if (state_q == ST_IACK && xfer_done) begin
      if (autovec_s) begin
        vec_q <= VEC_AUTOVEC_BASE + {5'h0, ack_level_q}; // RL8
      end else begin
        vec_q <= rdata_s[7:0]; // RL2 RL7 RL12
      end
    end
  end

  // Bus master: issues one cycle whenever the state needs one
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      bus_req_out <= 1'b0;
      release_q <= 1'b0;
      bus_write_out <= 1'b0;
      bus_long_out <= 1'b0;
      bus_fc_out <= FC_SUPER_PROG;
      bus_addr_out <= '0;
      bus_wdata_out <= '0;
    end else if (xfer_done) begin
      bus_req_out <= 1'b0;
      release_q <= 1'b1;
    end else if (release_q) begin
      release_q <= ack_s;
    end else if (step) begin
      unique case (state_q)
        ST_RST_SP, ST_RST_PC: begin
          bus_req_out <= 1'b1;
          bus_write_out <= 1'b0;
          bus_long_out <= 1'b1;
          bus_fc_out <= FC_SUPER_PROG; // RL4 RL20
          bus_addr_out <= ADDR_W'(RESET_VEC_ADDR) + ((state_q == ST_RST_PC) ? ADDR_W'(4) : '0); // RL5
        end
        ST_IACK: begin
          bus_req_out <= 1'b1;
          bus_write_out <= 1'b0;
          bus_long_out <= 1'b0;
          bus_fc_out <= FC_CPU_SPACE; // RL21
          bus_addr_out <= ADDR_W'({12'h0, CPU_TYPE_IACK, 11'h0, 1'b0, ack_level_q, 1'b0}); // RL21 RL22
        end
        ST_PUSH: begin
          bus_req_out <= 1'b1;
          bus_write_out <= 1'b1;
          bus_long_out <= 1'b0;
          bus_fc_out <= FC_SUPER_DATA;
          bus_addr_out <= ADDR_W'(push_addr); // RL24
          unique case (word_cnt_q)
            2'h0: bus_wdata_out <= {16'h0, FRAME_FMT_SHORT, 2'b00, vec_q, 2'b00}; // RL16 RL17
            2'h1: bus_wdata_out <= {16'h0, saved_pc_q[15:0]}; // RL15
            2'h2: bus_wdata_out <= {16'h0, saved_pc_q[31:16]}; // RL15
            2'h3: bus_wdata_out <= {16'h0, saved_psw_q}; // RL15
          endcase
        end
        ST_VFETCH: begin
          bus_req_out <= 1'b1;
          bus_write_out <= 1'b0;
          bus_long_out <= 1'b1; // RL23
          bus_fc_out <= FC_SUPER_DATA; // RL4
          bus_addr_out <= ADDR_W'(vbr_q + {22'h0, vec_q, 2'b00}); // RL1 RL6
        end
        default: bus_req_out <= 1'b0;
      endcase
    end
  end

  // Table base: software relocates it at any time
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      vbr_q <= VBR_RESET;
    end else if (reg_wr_in && reg_addr_in == OFS_VBR) begin
      vbr_q <= reg_wdata_in; // RL5
    end
  end

  // Status word: saved copy then supervisor switch at entry
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      psw_q <= PSW_RESET;
      saved_psw_q <= '0;
    end else if (state_q == ST_IDLE && (pend_q || irq_take)) begin
      saved_psw_q <= psw_q; // RL14
      psw_q[PSW_S] <= 1'b1; // RL14
      psw_q[PSW_T1] <= 1'b0; // RL14
      psw_q[PSW_T0] <= 1'b0; // RL14
      if (!pend_q) psw_q[PSW_MASK_LO +: 3] <= irq_s; // RL14
    end else if (reg_wr_in && reg_addr_in == OFS_PSW) begin
      psw_q <= reg_wdata_in[15:0];
    end
  end

  // Supervisor stack pointer and program counter
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      ssp_q <= '0;
      pc_q <= '0;
      saved_pc_q <= '0;
    end else begin
      if (state_q == ST_IDLE && pend_q) saved_pc_q <= pend_pc_q;
      else if (state_q == ST_IDLE && irq_take) saved_pc_q <= fault_pc_in;
      if (state_q == ST_RST_SP && xfer_done) begin
        ssp_q <= rdata_s; // RL3 RL20
      end else if (state_q == ST_PUSH && xfer_done && word_cnt_q == FRAME_WORDS_LAST[1:0]) begin
        ssp_q <= push_addr; // RL24
      end else if (reg_wr_in && reg_addr_in == OFS_SSP) begin
        ssp_q <= reg_wdata_in;
      end
      if ((state_q == ST_VFETCH || state_q == ST_RST_PC) && xfer_done) begin
        pc_q <= rdata_s; // RL18 RL23
      end else if (reg_wr_in && reg_addr_in == OFS_PC) begin
        pc_q <= reg_wdata_in;
      end
    end
  end

  // Outputs and resume pulse
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      resume_out <= 1'b0;
      busy_out <= 1'b1;
      pc_out <= '0;
      psw_out <= PSW_RESET;
    end else begin
      resume_out <= (state_q == ST_DONE) && step && !pend_q && !new_event; // RL18
      busy_out <= (state_q != ST_IDLE);
      pc_out <= pc_q;
      psw_out <= psw_q;
    end
  end

  // Register read port, zero for unmapped offsets
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_VBR: reg_rdata_out <= vbr_q;
        OFS_PSW: reg_rdata_out <= {16'h0, psw_q};
        OFS_SSP: reg_rdata_out <= ssp_q;
        OFS_PC: reg_rdata_out <= pc_q;
        OFS_STATUS: reg_rdata_out <= {12'h0, pend_q, state_q, vec_q, 8'h0};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  property p_vec_addr;
    $rose(bus_req_out) && state_q == ST_VFETCH |-> bus_addr_out == ADDR_W'(vbr_q + {22'h0, vec_q, 2'b00});
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // RL6
  property p_vec_space;
    bus_req_out && state_q == ST_VFETCH |-> bus_fc_out == FC_SUPER_DATA && bus_long_out && !bus_write_out;
  endproperty
  a_vec_space: assert property (p_vec_space) else $error("vector fetch space wrong"); // RL4
  property p_rst_fetch;
    bus_req_out && (state_q == ST_RST_SP || state_q == ST_RST_PC)
      |-> bus_fc_out == FC_SUPER_PROG && bus_addr_out[ADDR_W-1:3] == '0;
  endproperty
  a_rst_fetch: assert property (p_rst_fetch) else $error("reset fetch wrong"); // RL20
  property p_iack;
    bus_req_out && state_q == ST_IACK
      |-> bus_fc_out == FC_CPU_SPACE && bus_addr_out[19:16] == CPU_TYPE_IACK && bus_addr_out[4:1] == {1'b0, ack_level_q};
  endproperty
  a_iack: assert property (p_iack) else $error("acknowledge cycle wrong"); // RL21
  property p_autovec;
    state_q == ST_IACK && xfer_done && autovec_s |=> vec_q == VEC_AUTOVEC_BASE + {5'h0, $past(ack_level_q)};
  endproperty
  a_autovec: assert property (p_autovec) else $error("autovector wrong"); // RL8

  property p_super;
    state_q == ST_IDLE && (pend_q || irq_take) |=> psw_q[PSW_S] && !psw_q[PSW_T1] && !psw_q[PSW_T0]
      && saved_psw_q == $past(psw_q);
  endproperty
  a_super: assert property (p_super) else $error("status switch wrong"); // RL14

  property p_frame_fmt;
    $rose(bus_req_out) && state_q == ST_PUSH && word_cnt_q == 2'h0
      |-> bus_wdata_out[15:12] == FRAME_FMT_SHORT && bus_wdata_out[11:0] == {2'b00, vec_q, 2'b00};
  endproperty
  a_frame_fmt: assert property (p_frame_fmt) else $error("frame format word wrong"); // RL16

  property p_push_down;
    state_q == ST_PUSH && xfer_done && word_cnt_q == 2'h3 |=> ssp_q == $past(ssp_q) - 32'h8;
  endproperty
  a_push_down: assert property (p_push_down) else $error("stack not lowered by frame"); // RL24

  property p_resume;
    resume_out |-> state_q == ST_IDLE ##1 pc_out == pc_q;
  endproperty
  a_resume: assert property (p_resume) else $error("resume without handler load"); // RL18

  c_reset_done: cover property (state_q == ST_RST_PC && xfer_done);
  c_irq_taken: cover property (state_q == ST_IACK && xfer_done ##[1:200] resume_out);
  c_trap_taken: cover property (exc_req_in && exc_cause_in == CAUSE_TRAP ##[1:300] resume_out);
endmodule

// File: bus_partner.sv
// System bus partner: word memory plus interrupt vector source, four-phase acknowledge
module bus_partner (
  input wire logic clk_in, // Core clock
  input wire logic req_in, // Bus cycle request
  input wire logic write_in, // Cycle is a write
  input wire logic long_in, // Long cycle
  input wire logic [2:0] fc_in, // Function code
  input wire logic [31:0] addr_in, // Address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic [3:0] delay_in, // Wait cycles before acknowledge
  input wire logic autovec_en_in, // Answer acknowledge cycles by autovector
  input wire logic [7:0] iack_vec_in, // Vector returned otherwise
  output logic ack_out, // Acknowledge pin
  output logic autovec_out, // Autovector pin
  output logic [31:0] rdata_out, // Read data pins
  output logic [2:0] rd_fc_out, // Function code of last memory read
  output logic [31:0] rd_addr_out, // Address of last memory read
  output logic [31:0] iack_addr_out // Address of last acknowledge cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem16 [logic [31:0]]; // Word memory, byte addressed
  int unsigned wait_q; // Cycles left before acknowledge
  // Preload one long word, high half first
  task automatic put_long(input logic [31:0] a, input logic [31:0] v);
    mem16[a] = v[31:16];
    mem16[a + 32'h2] = v[15:0];
  endtask
  // Unwritten words read as a marker
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {16'h0, mem16.exists(a) ? mem16[a] : 16'hdead};
  endfunction
  initial begin
    ack_out = 1'b0;
    autovec_out = 1'b0;
    rdata_out = 32'h5a5a_a5a5;
    rd_fc_out = 3'h0;
    rd_addr_out = '0;
    iack_addr_out = '0;
    wait_q = 0;
  end
  // Responder: ack after the delay, held until request drops; idle data lines toggle each cycle
  always @(posedge clk_in) begin
    if (!req_in) begin
      ack_out <= 1'b0;
      autovec_out <= 1'b0;
      rdata_out <= ~rdata_out;
      wait_q <= delay_in;
    end else if (!ack_out && wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else if (!ack_out) begin
      ack_out <= 1'b1;
      // Acknowledge cycle: CPU space, type field all ones
      if (fc_in == 3'h7 && addr_in[19:16] == 4'hf) begin
        autovec_out <= autovec_en_in;
        rdata_out <= {24'h0, iack_vec_in};
        iack_addr_out <= addr_in;
      end else if (write_in) begin
        mem16[addr_in] = wdata_in[15:0];
      end else begin
        // Table reads only; processor vectors are never written from here
        rdata_out <= long_in ? ((word_at(addr_in) << 16) | word_at(addr_in + 32'h2)) : word_at(addr_in);
        rd_fc_out <= fc_in;
        rd_addr_out <= addr_in;
      end
    end
  end
endmodule

// File: tb_top.sv
// Self-checking bench for the exception vector sequencer
module tb_top
  import exc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rstn_in, reg_wr_in, reg_rd_in, exc_req_in, fetch_valid_in, oper_valid_in, oper_wide_in;
  logic priv_instr_in, bus_ack_in, bus_autovec_in, bus_req_out, bus_write_out, bus_long_out, busy_out, resume_out;
  logic [7:0] reg_addr_in; // Register address
  logic [31:0] reg_wdata_in, reg_rdata_out, fetch_addr_in, oper_addr_in, fault_pc_in, bus_rdata_in;
  logic [31:0] bus_addr_out, bus_wdata_out, pc_out, raddr, iaddr;
  exc_cause_t exc_cause_in; // Reported cause
  logic [3:0] trap_num_in, dly; // Trap variant, partner delay
  logic [2:0] irq_level_in, bus_fc_out, rfc; // Level pins, function codes
  logic [15:0] psw_out; // Status word
  logic aven; // Partner autovectors
  logic [7:0] ivec; // Partner-supplied vector
  int miscompares, n_compared; // Counters
  exception_vector_sequencer dut (.mclk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .exc_req_in, .exc_cause_in, .trap_num_in, .fetch_valid_in, .fetch_addr_in, .oper_valid_in,
    .oper_wide_in, .oper_addr_in, .priv_instr_in, .fault_pc_in, .irq_level_in, .bus_ack_in, .bus_autovec_in,
    .bus_rdata_in, .bus_req_out, .bus_write_out, .bus_long_out, .bus_fc_out, .bus_addr_out, .bus_wdata_out,
    .pc_out, .psw_out, .busy_out, .resume_out);
  bus_partner bp (.clk_in(mclk_in), .req_in(bus_req_out), .write_in(bus_write_out), .long_in(bus_long_out),
    .fc_in(bus_fc_out), .addr_in(bus_addr_out), .wdata_in(bus_wdata_out), .delay_in(dly), .autovec_en_in(aven),
    .iack_vec_in(ivec), .ack_out(bus_ack_in), .autovec_out(bus_autovec_in), .rdata_out(bus_rdata_in),
    .rd_fc_out(rfc), .rd_addr_out(raddr), .iack_addr_out(iaddr));
  // 40 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // Bounded wait for the resume pulse, which must last one cycle
  task automatic wait_resume();
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge mclk_in);
      #1;
      if (resume_out === 1'b1) break;
    end
    if (i == 2000) begin
      miscompares++;
      results();
    end
    @(posedge mclk_in);
    #1 chk({30'h0, busy_out, resume_out}, 32'h0);
  endtask
  // Arms stack and status, fires one event kind, then judges handler, fetch, status and frame
  task automatic entry(input int kind, input exc_cause_t c, input logic [3:0] n, input logic [7:0] vec,
    input logic [2:0] lvl);
    logic [31:0] d;
    bp.put_long(32'h7ff8, 32'hffff_ffff);
    bp.put_long(32'h7ffc, 32'hffff_ffff);
    reg_wr(8'h08, 32'h0000_8000);
    reg_wr(8'h04, 32'h0000_c000);
    @(posedge mclk_in);
    case (kind)
      0: begin
        exc_req_in <= 1'b1;
        exc_cause_in <= c;
        trap_num_in <= n;
      end
      1: begin
        fetch_valid_in <= 1'b1;
        fetch_addr_in <= 32'h0000_1001;
      end
      2: begin
        oper_valid_in <= 1'b1;
        oper_wide_in <= 1'b1;
        oper_addr_in <= 32'h0000_2003;
      end
      3: priv_instr_in <= 1'b1;
      default: irq_level_in <= lvl;
    endcase
    @(posedge mclk_in);
    exc_req_in <= 1'b0;
    fetch_valid_in <= 1'b0;
    oper_valid_in <= 1'b0;
    priv_instr_in <= 1'b0;
    irq_level_in <= 3'h0;
    wait_resume();
    @(posedge mclk_in);
    chk(pc_out, {20'h00030, vec, 4'h0});
    chk(raddr, 32'h2000 + {22'h0, vec, 2'b00});
    chk({29'h0, rfc}, 32'h5);
    chk({16'h0, psw_out}, {16'h0, 5'b00100, lvl, 8'h00});
    chk(bp.word_at(32'h7ff8), 32'hc000);
    chk(bp.word_at(32'h7ffa), 32'h00c0);
    chk(bp.word_at(32'h7ffc), 32'hffe4);
    chk(bp.word_at(32'h7ffe), {22'h0, vec, 2'b00});
    reg_rd(8'h08, d);
    chk(d, 32'h7ff8);
    if (kind == 4) begin
      chk({28'h0, iaddr[19:16]}, 32'hf);
      chk({28'h0, iaddr[4:1]}, {29'h0, lvl});
    end
  endtask
  // Reset fetch, register defaults, unmapped read, table relocation
  task automatic t_reset();
    logic [31:0] d;
    wait_resume();
    chk(pc_out, 32'h0000_0400);
    chk(raddr, 32'h4);
    chk({29'h0, rfc}, 32'h6);
    chk({16'h0, psw_out}, 32'h2700);
    reg_rd(8'h08, d);
    chk(d, 32'h9000);
    reg_rd(8'h14, d);
    chk(d, 32'h0);
    reg_wr(8'h00, 32'h2000);
    reg_rd(8'h00, d);
    chk(d, 32'h2000);
    $display("test reset done");
  endtask
  // Every fixed-vector cause, prompt and slow partner in turn
  task automatic t_fixed();
    exc_cause_t cs [12] = '{CAUSE_ILLEGAL, CAUSE_ZERO_DIV, CAUSE_BOUND, CAUSE_COND_TRAP, CAUSE_PRIV,
      CAUSE_TRACE, CAUSE_LINE_A, CAUSE_LINE_F, CAUSE_HW_BREAKPOINT_INSTR, CAUSE_FORMAT, CAUSE_BUS_ERR, CAUSE_ADDR_ERR};
    logic [7:0] vs [12] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h02, 8'h03};
    for (int i = 0; i < 12; i++) begin
      dly = i[0] ? 4'h6 : 4'h0;
      entry(0, cs[i], 4'h0, vs[i], 3'h0);
    end
    $display("test fixed done");
  endtask
  // All sixteen trap variants
  task automatic t_trap();
    for (int n = 0; n < 16; n++) entry(0, CAUSE_TRAP, n[3:0], 8'h20 + 8'(n), 3'h0);
    $display("test trap done");
  endtask
  // Odd fetch, odd wide operand, privileged instruction in user state
  task automatic t_internal();
    entry(1, CAUSE_ILLEGAL, 4'h0, 8'h03, 3'h0);
    entry(2, CAUSE_ILLEGAL, 4'h0, 8'h03, 3'h0);
    entry(3, CAUSE_ILLEGAL, 4'h0, 8'h08, 3'h0);
    $display("test internal done");
  endtask
  // Autovectors for levels 1 to 7, then vectors supplied by the source
  task automatic t_irq();
    aven = 1'b1;
    for (int l = 1; l < 8; l++) entry(4, CAUSE_ILLEGAL, 4'h0, 8'h18 + 8'(l), l[2:0]);
    aven = 1'b0;
    ivec = 8'h40;
    entry(4, CAUSE_ILLEGAL, 4'h0, 8'h40, 3'h2);
    ivec = 8'hff;
    dly = 4'h5;
    entry(4, CAUSE_ILLEGAL, 4'h0, 8'hff, 3'h5);
    $display("test irq done");
  endtask
  // Main sequence
  initial begin
    {rstn_in, reg_wr_in, reg_rd_in, exc_req_in, fetch_valid_in, oper_valid_in, oper_wide_in, priv_instr_in} = '0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    trap_num_in = '0;
    fetch_addr_in = '0;
    oper_addr_in = '0;
    irq_level_in = '0;
    exc_cause_in = CAUSE_ILLEGAL;
    fault_pc_in = 32'h00c0_ffe4;
    dly = 4'h1;
    aven = 1'b0;
    ivec = 8'h00;
    miscompares = 0;
    n_compared = 0;
    bp.put_long(32'h0, 32'h0000_9000);
    bp.put_long(32'h4, 32'h0000_0400);
    for (int v = 0; v < 256; v++) bp.put_long(32'h2000 + 32'(v) * 4, 32'h0003_0000 + 32'(v) * 16);
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_fixed();
    t_trap();
    t_internal();
    t_irq();
    results();
  end
endmodule
